// ===== rtl/pts_timebase.sv
// timebase selection, 16-bit counter, overflow flag and mode register
`timescale 1ns/1ps
`include "pts_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - bit 4 of the mode register reads zero; writes to it are dropped
// - select 000 ticks every 12 clocks, select 001 every 4 clocks
// - select 010 ticks on each timer 0 overflow pulse
// - select 011 counts falling edges of the count input, source at most clock/4
// - select 100 ticks on every system clock
// - select 101 ticks every 8 synchronised external oscillator cycles
// - select 110 ticks every 8 synchronised rtc oscillator cycles; 111 reserved
// - overflow request goes out only while enable is 1 and flag set
// - once lock is set, watchdog enable cannot be cleared until reset
module pts_timebase (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// mode register access
	input  wire logic        mode_wr,
	input  wire logic [7:0]  mode_wdata,
	output logic      [7:0]  mode_rdata,
	// overflow flag control
	input  wire logic        flag_clear,
	output logic             counter_overflow_flag,
	output logic             overflow_irq,
	// counter
	output logic      [15:0] counter_value,
	// count sources
	input  wire logic        timer0_overflow,
	input  wire logic        external_count_input,
	input  wire logic        ext_osc_in,
	input  wire logic        rtc_osc_in
);
	////////////////////////////////////////////////////////////////////////////
	// reset release
	// asserts at once; release is retimed so no flop leaves reset on a runt edge
	logic rst_meta_q;
	logic rst_b_sync;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_b_sync <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_b_sync <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	pts_sync_if lanes ();

	assign lanes.raw[`PTS_LANE_ECI] = external_count_input;
	assign lanes.raw[`PTS_LANE_EXT] = ext_osc_in;
	assign lanes.raw[`PTS_LANE_RTC] = rtc_osc_in;

	pts_sync u_sync (
		.clock      (clock),
		.rst_b_sync (rst_b_sync),
		.lanes      (lanes.sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// mode register
	logic [7:0] mode_q;
	logic [7:0] mode_d;

	always_comb begin
		mode_d = mode_q;
		if (mode_wr) begin
			mode_d = mode_wdata;
			mode_d[`PTS_BIT_UNUSED] = 1'b0;
			// lock is sticky; a locked enable may be set but never cleared
			mode_d[`PTS_BIT_WDOG_LOCK] = mode_q[`PTS_BIT_WDOG_LOCK]
				| mode_wdata[`PTS_BIT_WDOG_LOCK];
			if (mode_q[`PTS_BIT_WDOG_LOCK]) begin
				mode_d[`PTS_BIT_WDOG_EN] = mode_q[`PTS_BIT_WDOG_EN]
					| mode_wdata[`PTS_BIT_WDOG_EN];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b_sync) begin
		if (!rst_b_sync) begin
			mode_q <= `PTS_MODE_RESET;
		end else begin
			mode_q <= mode_d;
		end
	end

	pts_pkg::pts_src_t sel;
	assign sel = pts_pkg::pts_src_t'(mode_q[`PTS_SEL_HI:`PTS_SEL_LO]);

	////////////////////////////////////////////////////////////////////////////
	// edge detection and dividers
	// history resets low: a pin idling high shows one rise after reset
	logic [`PTS_LANES-1:0] prev_q;
	logic [`PTS_LANES-1:0] prev_d;
	logic [3:0]            pre_q;
	logic [3:0]            pre_d;
	logic [2:0]            ext_div_q;
	logic [2:0]            ext_div_d;
	logic [2:0]            rtc_div_q;
	logic [2:0]            rtc_div_d;
	logic                  eci_fall;
	logic                  ext_rise;
	logic                  rtc_rise;
	logic                  tick;

	always_comb begin
		prev_d    = lanes.synced;
		eci_fall  = prev_q[`PTS_LANE_ECI] & ~lanes.synced[`PTS_LANE_ECI];
		ext_rise  = ~prev_q[`PTS_LANE_EXT] & lanes.synced[`PTS_LANE_EXT];
		rtc_rise  = ~prev_q[`PTS_LANE_RTC] & lanes.synced[`PTS_LANE_RTC];
		pre_d     = pre_q + `PTS_PRE_ONE;
		ext_div_d = ext_div_q;
		rtc_div_d = rtc_div_q;
		tick      = 1'b0;
		// oscillator dividers run freely so a select change sees a steady phase
		if (ext_rise) begin
			ext_div_d = ext_div_q + `PTS_OSC_ONE;
		end
		if (rtc_rise) begin
			rtc_div_d = rtc_div_q + `PTS_OSC_ONE;
		end
		unique case (sel)
			pts_pkg::PTS_SRC_DIV12: begin
				tick = (pre_q >= `PTS_PRE_DIV12);
				if (tick) begin
					pre_d = `PTS_PRE_ZERO;
				end
			end
			pts_pkg::PTS_SRC_DIV4: begin
				tick = (pre_q >= `PTS_PRE_DIV4);
				if (tick) begin
					pre_d = `PTS_PRE_ZERO;
				end
			end
			pts_pkg::PTS_SRC_T0OVF:  tick = timer0_overflow;
			pts_pkg::PTS_SRC_ECI:    tick = eci_fall;
			pts_pkg::PTS_SRC_SYSCLK: tick = 1'b1;
			pts_pkg::PTS_SRC_EXTOSC:
				tick = ext_rise & (ext_div_q == `PTS_OSC_DIV8);
			pts_pkg::PTS_SRC_RTCOSC:
				tick = rtc_rise & (rtc_div_q == `PTS_OSC_DIV8);
			// reserved code: counter holds
			pts_pkg::PTS_SRC_RSVD:   tick = 1'b0;
		endcase
		if (sel != pts_pkg::PTS_SRC_DIV12 && sel != pts_pkg::PTS_SRC_DIV4) begin
			pre_d = `PTS_PRE_ZERO;
		end
	end

	always_ff @(posedge clock or negedge rst_b_sync) begin
		if (!rst_b_sync) begin
			prev_q    <= '0;
			pre_q     <= `PTS_PRE_ZERO;
			ext_div_q <= `PTS_OSC_ZERO;
			rtc_div_q <= `PTS_OSC_ZERO;
		end else begin
			prev_q    <= prev_d;
			pre_q     <= pre_d;
			ext_div_q <= ext_div_d;
			rtc_div_q <= rtc_div_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counter
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic        wrap;

	always_comb begin
		count_d = count_q;
		wrap    = 1'b0;
		if (tick) begin
			count_d = count_q + `PTS_COUNT_ONE;
			wrap    = (count_q == `PTS_COUNT_ALL1);
		end
	end

	always_ff @(posedge clock or negedge rst_b_sync) begin
		if (!rst_b_sync) begin
			count_q <= `PTS_COUNT_RESET;
		end else begin
			count_q <= count_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// overflow flag and request
	logic flag_q;
	logic flag_d;
	logic irq_q;
	logic irq_d;

	always_comb begin
		// set wins over a clear in the same cycle
		flag_d = wrap | (flag_q & ~flag_clear);
		// built from next values so the request lines up with flag and enable
		irq_d  = flag_d & mode_d[`PTS_BIT_IRQ_EN];
	end

	always_ff @(posedge clock or negedge rst_b_sync) begin
		if (!rst_b_sync) begin
			flag_q <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			flag_q <= flag_d;
			irq_q  <= irq_d;
		end
	end

	assign mode_rdata            = mode_q;
	assign counter_value         = count_q;
	assign counter_overflow_flag = flag_q;
	assign overflow_irq          = irq_q;
endmodule // pts_timebase

// ===== rtl/pts_defines.svh
// named constants for the counter timebase select block
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH

// mode register field positions
`define PTS_BIT_IDLE      7
`define PTS_BIT_WDOG_EN   6
`define PTS_BIT_WDOG_LOCK 5
`define PTS_BIT_UNUSED    4
`define PTS_SEL_HI        3
`define PTS_SEL_LO        1
`define PTS_BIT_IRQ_EN    0

// reset values and counter constants
`define PTS_MODE_RESET    8'h00
`define PTS_COUNT_RESET   16'h0000
`define PTS_COUNT_ALL1    16'hFFFF
`define PTS_COUNT_ONE     16'h0001

// prescaler terminal counts (period minus one)
`define PTS_PRE_ZERO      4'h0
`define PTS_PRE_ONE       4'h1
`define PTS_PRE_DIV12     4'hB
`define PTS_PRE_DIV4      4'h3
`define PTS_OSC_ZERO      3'h0
`define PTS_OSC_ONE       3'h1
`define PTS_OSC_DIV8      3'h7

// synchronised input lanes
`define PTS_LANE_ECI      0
`define PTS_LANE_EXT      1
`define PTS_LANE_RTC      2
`define PTS_LANES         3

`endif

// ===== rtl/pts_pkg.sv
// types for the counter timebase select block
package pts_pkg;
	typedef enum logic [2:0] {
		PTS_SRC_DIV12 = 3'h0,
		PTS_SRC_DIV4  = 3'h1,
		PTS_SRC_T0OVF = 3'h2,
		PTS_SRC_ECI   = 3'h3,
		PTS_SRC_SYSCLK = 3'h4,
		PTS_SRC_EXTOSC = 3'h5,
		PTS_SRC_RTCOSC = 3'h6,
		PTS_SRC_RSVD  = 3'h7
	} pts_src_t;
endpackage

// ===== rtl/pts_sync_if.sv
// bundle of raw and synchronised input levels
`timescale 1ns/1ps
`include "pts_defines.svh"
interface pts_sync_if;
	logic [`PTS_LANES-1:0] raw;
	logic [`PTS_LANES-1:0] synced;
	modport core (output raw, input synced);
	modport sync (input raw, output synced);
endinterface

// ===== rtl/pts_sync.sv
// two-flop synchronisers for the asynchronous count and oscillator inputs
`timescale 1ns/1ps
`include "pts_defines.svh"
module pts_sync (
	// clock and reset
	input  wire logic  clock,
	input  wire logic  rst_b_sync,
	// levels
	pts_sync_if.sync   lanes
);
	logic [`PTS_LANES-1:0] meta_q;
	logic [`PTS_LANES-1:0] meta_d;
	logic [`PTS_LANES-1:0] sync_q;
	logic [`PTS_LANES-1:0] sync_d;

	genvar g;
	generate
		for (g = 0; g < `PTS_LANES; g = g + 1) begin : g_lane
			// first stage feeds only the second stage
			always_comb begin
				meta_d[g] = lanes.raw[g];
				sync_d[g] = meta_q[g];
			end
			always_ff @(posedge clock or negedge rst_b_sync) begin
				if (!rst_b_sync) begin
					meta_q[g] <= 1'b0;
					sync_q[g] <= 1'b0;
				end else begin
					meta_q[g] <= meta_d[g];
					sync_q[g] <= sync_d[g];
				end
			end
		end
	endgenerate

	assign lanes.synced = sync_q;
endmodule // pts_sync

// ===== sim/pts_timebase_asserts.sv
// port assertions for the timebase block
`timescale 1ns/1ps
module pts_timebase_chk (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// mode register and flag
	input wire logic        mode_wr,
	input wire logic [7:0]  mode_wdata,
	input wire logic [7:0]  mode_rdata,
	input wire logic        flag_clear,
	input wire logic        counter_overflow_flag,
	input wire logic        overflow_irq,
	// counter and sources
	input wire logic [15:0] counter_value,
	input wire logic        timer0_overflow,
	input wire logic        external_count_input,
	input wire logic        ext_osc_in,
	input wire logic        rtc_osc_in
);
	logic [2:0] sel;
	logic [2:0] sel_q;
	logic [4:0] run_q;
	assign sel = mode_rdata[3:1];
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// cycles the select has held: prescaler phase is only settled after a while
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sel_q <= 3'h0;
			run_q <= 5'h00;
		end else begin
			sel_q <= sel;
			run_q <= (sel != sel_q) ? 5'h00 : run_q + {4'h0, run_q != 5'h1F};
		end
	end
	AST_UNUSED_ZERO: assert property (mode_rdata[4] == 1'b0)
		else $error("unused bit reads one");
	AST_DIV12: assert property (sel == 3'h0 && sel == sel_q && run_q > 5'h13 |->
		counter_value - $past(counter_value, 12) == 16'h1) else $error("div12 rate");
	AST_DIV4: assert property (sel == 3'h1 && sel == sel_q && run_q > 5'h07 |->
		counter_value - $past(counter_value, 4) == 16'h1) else $error("div4 rate");
	AST_T0: assert property (sel == 3'h2 |=>
		counter_value == $past(counter_value) + $past(timer0_overflow)) else $error("t0 tick");
	AST_SYS: assert property (sel == 3'h4 |=>
		counter_value == $past(counter_value) + 16'h1) else $error("sysclk tick");
	AST_RSVD: assert property (sel == 3'h7 |=> $stable(counter_value))
		else $error("reserved select counts");
	AST_IRQ: assert property (overflow_irq == (counter_overflow_flag & mode_rdata[0]))
		else $error("irq mask");
	AST_LOCK: assert property (mode_rdata[6:5] == 2'b11 |=> mode_rdata[6:5] == 2'b11)
		else $error("lock lost");
	AST_WRAP: assert property (counter_value == 16'h0 && $past(counter_value) == 16'hFFFF
		|-> counter_overflow_flag) else $error("wrap without flag");
endmodule // pts_timebase_chk

// ===== sim/tb_top.sv
// self-checking bench for the timebase block
`timescale 1ns/1ps
module tb_top;
	logic        clock = 1'b0;
	logic        rst_b;
	logic        mode_wr;
	logic [7:0]  mode_wdata;
	logic [7:0]  mode_rdata;
	logic        flag_clear;
	logic        counter_overflow_flag;
	logic        overflow_irq;
	logic [15:0] counter_value;
	logic        timer0_overflow = 1'b0;
	logic        external_count_input = 1'b0;
	logic        ext_osc_in = 1'b0;
	logic        rtc_osc_in = 1'b0;
	logic [1:0]  ph = 2'h0;
	logic [15:0] base;
	int          failures = 0;
	int          checks = 0;
	// ticks expected per 96 clocks, row index is the select code
	logic [15:0] delta [8] = '{16'h8, 16'h18, 16'h18, 16'h18, 16'h60, 16'h6, 16'h3, 16'h0};
	always #50 clock = ~clock;
	pts_timebase dut_u (.clock, .rst_b, .mode_wr, .mode_wdata, .mode_rdata, .flag_clear,
		.counter_overflow_flag, .overflow_irq, .counter_value, .timer0_overflow,
		.external_count_input, .ext_osc_in, .rtc_osc_in);
	// periodic sources; periods divide 96 so the window phase never matters
	always @(posedge clock) begin
		ph <= ph + 2'h1;
		timer0_overflow <= ph == 2'h3;
		external_count_input <= ph[1];
		ext_osc_in <= ph[0];
		rtc_osc_in <= ph[1];
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge clock);
		mode_wr <= 1'b1;
		mode_wdata <= d;
		@(posedge clock);
		mode_wr <= 1'b0;
		step(1);
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		rst_b <= 1'b0;
		mode_wr <= 1'b0;
		mode_wdata <= 8'h00;
		flag_clear <= 1'b0;
		step(3);
		chk({mode_rdata, 6'h00, counter_overflow_flag, overflow_irq}, 16'h0);
		chk(counter_value, 16'h0);
		@(posedge clock);
		rst_b <= 1'b1;
		step(3);
		for (int k = 0; k < 8; k++) begin
			wr({4'h0, k[2:0], 1'b0});
			chk({8'h00, mode_rdata}, {12'h000, k[2:0], 1'b0});
			step(8);
			base = counter_value;
			step(96);
			chk(counter_value - base, delta[k]);
		end
		wr(8'h19);
		chk({8'h00, mode_rdata}, 16'h0009);
		for (int i = 0; i < 70000 && counter_value !== 16'hFFFF; i++) step(1);
		if (counter_value !== 16'hFFFF) begin
			failures++;
			$display("CHECK FAILED at %0t: counter never reached all ones", $time);
		end
		step(1);
		chk({14'h0, counter_overflow_flag, overflow_irq}, 16'h3);
		wr(8'h08);
		chk({14'h0, counter_overflow_flag, overflow_irq}, 16'h2);
		@(posedge clock);
		flag_clear <= 1'b1;
		@(posedge clock);
		flag_clear <= 1'b0;
		step(1);
		chk({14'h0, counter_overflow_flag, overflow_irq}, 16'h0);
		wr(8'h60);
		wr(8'h00);
		chk({8'h00, mode_rdata}, 16'h0060);
		// reset in mid-run is the only way out of the lock
		@(posedge clock);
		rst_b <= 1'b0;
		step(1);
		chk({mode_rdata, counter_value[7:0]}, 16'h0);
		@(posedge clock);
		rst_b <= 1'b1;
		step(3);
		wr(8'h40);
		wr(8'h00);
		chk({8'h00, mode_rdata}, 16'h0000);
		stop_test();
	end
endmodule // tb_top
bind pts_timebase pts_timebase_chk chk_u (.clock, .rst_b, .mode_wr, .mode_wdata, .mode_rdata,
	.flag_clear, .counter_overflow_flag, .overflow_irq, .counter_value, .timer0_overflow,
	.external_count_input, .ext_osc_in, .rtc_osc_in);
